// ==== code_lock_verify.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - scramble array holds 64 bytes, all ones until programmed
// - six low code address bits select the scramble byte on verify
// - verify byte is code byte XNOR scramble byte
// - no lock bits: no restrictions, verify still scrambled
// - first lock: block external code reads, latch pin at reset, no programming
// - second lock: level 2 restrictions plus verify disabled
// - third lock: level 3 restrictions plus external execution disabled
module code_lock_verify
  import code_lock_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [LOCK_W-1:0]     lock_bits_n,
  input  wire logic                  external_access_select_pin,
  input  wire logic                  prog_req,
  input  wire logic                  prog_scramble_sel,
  input  wire logic [CODE_AW-1:0]    prog_addr,
  input  wire logic [7:0]            prog_data,
  input  wire logic                  verify_req,
  input  wire logic [CODE_AW-1:0]    verify_addr,
  input  wire logic [7:0]            code_rdata,
  input  wire logic                  code_space_read_instruction,
  input  wire logic                  fetch_is_external,
  output logic                       code_prog_en,
  output logic                       scramble_prog_en,
  output logic [7:0]                 verify_data,
  output logic                       verify_valid,
  output logic                       verify_refused,
  output logic                       prog_refused,
  output logic                       internal_read_allow,
  output logic                       external_exec_allow,
  output logic                       ext_access_latched,
  output logic [1:0]                 sec_level
);
  sec_level_e level_next;
  sec_level_e level_reg;
  logic [7:0] scr_byte;
  logic       rst_seen_reg;
  logic       block_read;
  logic       block_prog;
  logic       block_verify;
  logic       block_ext;
  logic       verify_take;
  logic       prog_take;
  logic       scr_write;
  logic [7:0] verify_byte;
  logic       read_allow_next;

  always_comb
  begin
    if (!lock_bits_n[LOCK_THIRD])
      level_next = SEC_NOEXT;
    else if (!lock_bits_n[LOCK_SECOND])
      level_next = SEC_NOVERIF;
    else if (!lock_bits_n[LOCK_FIRST])
      level_next = SEC_NOREAD;
    else
      level_next = SEC_OPEN;
  end

  // reset parks at the strictest level until the pins are read
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      level_reg <= SEC_NOEXT;
    else
      level_reg <= level_next;
  end

  // restrictions follow the held level, not the live pins
  always_comb
  begin
    unique case (level_reg)
      SEC_OPEN:
      begin
        block_read   = 1'b0;
        block_prog   = 1'b0;
        block_verify = 1'b0;
        block_ext    = 1'b0;
      end
      SEC_NOREAD:
      begin
        block_read   = 1'b1;
        block_prog   = 1'b1;
        block_verify = 1'b0;
        block_ext    = 1'b0;
      end
      SEC_NOVERIF:
      begin
        block_read   = 1'b1;
        block_prog   = 1'b1;
        block_verify = 1'b1;
        block_ext    = 1'b0;
      end
      SEC_NOEXT:
      begin
        block_read   = 1'b1;
        block_prog   = 1'b1;
        block_verify = 1'b1;
        block_ext    = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    verify_take = verify_req && !block_verify;
    prog_take   = prog_req && !block_prog;
    scr_write   = prog_take && prog_scramble_sel;
    verify_byte = ~(code_rdata ^ scr_byte);
  end

  // only code reads run from outside are held off
  always_comb
  begin
    read_allow_next = 1'b1;
    if (code_space_read_instruction && fetch_is_external && block_read)
      read_allow_next = 1'b0;
  end

  scramble_array u_scr (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (scr_write),
    .wr_idx  (prog_addr[SCR_AW-1:0]),
    .wr_data (prog_data),
    .rd_idx  (verify_addr[SCR_AW-1:0]),
    .rd_data (scr_byte)
  );

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      verify_data    <= 8'h00;
      verify_valid   <= 1'b0;
      verify_refused <= 1'b0;
    end
    else
    begin
      verify_valid   <= verify_take;
      verify_refused <= verify_req && block_verify;
      // xnor with scramble byte
      // refused or idle leaves zero so nothing leaks
      if (verify_take)
        verify_data <= verify_byte;
      else
        verify_data <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      code_prog_en     <= 1'b0;
      scramble_prog_en <= 1'b0;
      prog_refused     <= 1'b0;
    end
    else
    begin
      code_prog_en     <= prog_take && !prog_scramble_sel;
      scramble_prog_en <= scr_write;
      prog_refused     <= prog_req && block_prog;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      internal_read_allow <= 1'b0;
    else
      internal_read_allow <= read_allow_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      external_exec_allow <= 1'b0;
    else
      external_exec_allow <= !block_ext;
  end

  // pin caught at first edge after release, held while locked
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rst_seen_reg <= 1'b0;
    else
      rst_seen_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ext_access_latched <= 1'b0;
    // open level lets the pin follow after the first edge
    else if (!rst_seen_reg || !block_read)
      ext_access_latched <= external_access_select_pin;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sec_level <= LEVEL_4;
    else
      sec_level <= level_reg;
  end
endmodule
`default_nettype wire

// ==== code_lock_pkg.sv ====
package code_lock_pkg;
  localparam int unsigned SCR_DEPTH     = 64;
  localparam int unsigned SCR_AW        = 6;
  localparam int unsigned CODE_AW       = 15;
  localparam logic [7:0]  SCR_RESET_VAL = 8'hFF;
  localparam int unsigned LOCK_W        = 3;
  localparam logic [2:0]  LOCK_UNPROG   = 3'h7;
  localparam int unsigned LOCK_FIRST    = 0;
  localparam int unsigned LOCK_SECOND   = 1;
  localparam int unsigned LOCK_THIRD    = 2;
  localparam logic [1:0]  LEVEL_1       = 2'h0;
  localparam logic [1:0]  LEVEL_2       = 2'h1;
  localparam logic [1:0]  LEVEL_3       = 2'h3;
  localparam logic [1:0]  LEVEL_4       = 2'h2;
  typedef enum logic [1:0] {
    SEC_OPEN    = 2'h0,
    SEC_NOREAD  = 2'h1,
    SEC_NOVERIF = 2'h3,
    SEC_NOEXT   = 2'h2
  } sec_level_e;
endpackage

// ==== scramble_array.sv ====
`timescale 1ns/100ps
`default_nettype none
module scramble_array
  import code_lock_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire logic [SCR_AW-1:0]     wr_idx,
  input  wire logic [7:0]            wr_data,
  input  wire logic [SCR_AW-1:0]     rd_idx,
  output logic      [7:0]            rd_data
);
  wire logic [7:0] cells [SCR_DEPTH];

  genvar i;
  generate
    for (i = 0; i < SCR_DEPTH; i++)
    begin : g_byte
      // erased all ones; reset leaves the cells alone
      logic [7:0] cell_reg = SCR_RESET_VAL;
      // programming can only clear bits, never during reset
      always_ff @(posedge clk_sys)
      begin
        if (!sys_rst && wr_en && (wr_idx == SCR_AW'(i)))
          cell_reg <= cell_reg & wr_data;
      end
      assign cells[i] = cell_reg;
    end
  endgenerate

  assign rd_data = cells[rd_idx];
endmodule
`default_nettype wire

// ==== code_lock_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module code_lock_sva
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [2:0] lock_bits_n,
  input wire logic       prog_req,
  input wire logic       verify_req,
  input wire logic [7:0] verify_data,
  input wire logic       verify_valid,
  input wire logic       verify_refused,
  input wire logic       prog_refused,
  input wire logic       internal_read_allow,
  input wire logic       external_exec_allow,
  input wire logic       ext_access_latched,
  input wire logic [1:0] sec_level
);
  logic [2:0] up_reg;
  // level output settles two edges after reset, so wait seven
  always_ff @(posedge clk_sys)
  begin
    up_reg <= sys_rst ? 3'h0 : up_reg + {2'h0, up_reg != 3'h7};
  end
  wire logic ok = up_reg == 3'h7;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_verify_pass: assert property (ok && verify_req && !sec_level[1] |=> verify_valid)
    else $error("verify not answered");
  a_verify_block: assert property (ok && verify_req && sec_level[1] |=> verify_refused)
    else $error("verify not refused");
  a_prog_block: assert property (ok && prog_req && sec_level != 2'h0 |=> prog_refused)
    else $error("program not refused");
  a_data_idle: assert property (!verify_valid |-> verify_data == 8'h00)
    else $error("verify data not idle");
  a_exec_block: assert property (ok && sec_level == 2'h2 |-> !external_exec_allow)
    else $error("external run allowed");
  a_level_open: assert property (ok && sec_level == 2'h0 |-> internal_read_allow)
    else $error("open level restricted");
  a_pin_frozen: assert property (ok && sec_level != 2'h0 |=> $stable(ext_access_latched))
    else $error("pin latch moved");
  a_lock_union: assert property (ok && !lock_bits_n[2] |-> sec_level == 2'h2)
    else $error("level not strictest");
  cover property (verify_valid);
  cover property (verify_refused);
  cover property (prog_refused);
  cover property (ok && !external_exec_allow);
endmodule
bind code_lock_verify code_lock_sva i_code_lock_sva (.*);
`default_nettype wire

// ==== prog_station.sv ====
`timescale 1ns/100ps
`default_nettype none
module prog_station
(
  input  wire logic        clk_sys,
  output var  logic        prog_req = 1'b0,
  output var  logic        verify_req = 1'b0,
  output var  logic [14:0] prog_addr = 15'h0000,
  output var  logic [7:0]  prog_data = 8'h00,
  output wire logic [7:0]  code_rdata
);
  assign code_rdata = prog_addr[7:0] ^ 8'h3C;
  task automatic io(input logic p, input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    prog_req <= p;
    verify_req <= !p;
    prog_addr <= a;
    prog_data <= d;
    @(posedge clk_sys);
    prog_req <= 1'b0;
    verify_req <= 1'b0;
    prog_data <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

// ==== code_lock_verify_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module code_lock_verify_tb;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, external_access_select_pin = 1'b1;
  logic        prog_scramble_sel = 1'b1, code_space_read_instruction = 1'b1;
  logic        fetch_is_external = 1'b1, prog_req, verify_req, p;
  logic        code_prog_en, scramble_prog_en, verify_valid, verify_refused, prog_refused;
  logic        internal_read_allow, external_exec_allow, ext_access_latched;
  logic [2:0]  lock_bits_n = 3'h7;
  logic [14:0] prog_addr;
  logic [7:0]  prog_data, code_rdata, verify_data;
  logic [1:0]  sec_level;
  logic [30:0] rows [5] = '{31'h00C3FFFF, 31'h00410F8D, 31'h7FFFA599, 31'h01C35A5A, 31'h0001FFCD};
  logic [17:0] lk [5] = '{18'h335CD, 18'h2FD00, 18'h1D900, 18'h27D00, 18'h386C2};
  int          n_fail = 0;
  int          num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  prog_station i_prog_station (.*);
  code_lock_verify i_code_lock_verify (.verify_addr(prog_addr), .*);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic rst(input logic [2:0] l);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    lock_bits_n <= l;
    external_access_select_pin <= 1'b1;
    repeat (14) @(posedge clk_sys);
    #1 chk({1'b0, sec_level, verify_valid, prog_refused, external_exec_allow,
      internal_read_allow, ext_access_latched}, 8'h40);
    chk({5'h00, code_prog_en, scramble_prog_en, verify_refused}, 8'h00);
    chk(verify_data, 8'h00);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    // checker waits seven edges before it trusts the level
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rst(3'h7);
    foreach (rows[i])
    begin
      i_prog_station.io(1'b1, rows[i][30:16], rows[i][15:8]);
      chk({7'h00, scramble_prog_en}, 8'h01);
      i_prog_station.io(1'b0, rows[i][30:16], 8'h00);
      chk(verify_data, rows[i][7:0]);
    end
    $display("test verify done");
    foreach (lk[i])
    begin
      rst(lk[i][17:15]);
      external_access_select_pin <= 1'b0;
      i_prog_station.io(1'b1, 15'h0001, 8'h00);
      p = prog_refused;
      i_prog_station.io(1'b0, 15'h0001, 8'h00);
      chk({1'b0, sec_level, p, verify_refused, external_exec_allow, internal_read_allow,
        ext_access_latched}, {1'b0, lk[i][14:8]});
      chk(verify_data, lk[i][7:0]);
      $display("test lock %0d done", i);
    end
    // code array refusal and internal reads at level 2, then grant when open
    rst(3'h6);
    prog_scramble_sel <= 1'b0;
    code_space_read_instruction <= 1'b0;
    i_prog_station.io(1'b1, 15'h0002, 8'h12);
    chk({5'h00, code_prog_en, prog_refused, internal_read_allow}, 8'h03);
    rst(3'h7);
    i_prog_station.io(1'b1, 15'h0002, 8'h12);
    chk({6'h00, code_prog_en, scramble_prog_en}, 8'h02);
    $display("test code path done");
    end_sim;
  end
endmodule
`default_nettype wire
